// ==== design/sld_driver.sv ====
// Segment display driver: control registers, prescaler, phase sequencer, pin waveforms.
// Assumes a byte register port on ref_clk and a slow source clock arriving as a pin.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sld_driver (
    input wire logic ref_clk, // 10 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [5:0] reg_addr, // Register byte address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic slow_source_clock, // Slow source clock pin
    output logic [7:0] fp_level [0:39], // Unused; see level outputs below
    output logic [1:0] backplane_outputs [0:3], // Backplane drive level
    output logic [3:0] backplane_oe_n, // Backplane output enable, low drives
    output logic [1:0] frontplane_outputs [0:39], // Frontplane drive level
    output logic [39:0] frontplane_oe_n, // Frontplane output enable, low drives
    output logic frame_start, // One-cycle pulse at each frame start
    output logic bias_half // Level scheme: 1 for half bias, else third or full
);
    localparam int NB = sld_pkg::NUM_BP;
    localparam int NF = sld_pkg::NUM_FP;

    // Byte index into segment memory for a register address
    function automatic logic [4:0] ram_index(input logic [5:0] a);
        logic [5:0] d;
        d = a - sld_pkg::OFF_RAM0;
        return d[4:0];
    endfunction : ram_index

    function automatic logic is_ram(input logic [5:0] a);
        return (a >= sld_pkg::OFF_RAM0) && (a <= sld_pkg::OFF_RAM_LAST);
    endfunction : is_ram

    // Number of active backplanes minus one, from duty code
    function automatic logic [1:0] last_phase(input logic [1:0] m);
        case (m)
            sld_pkg::SLD_MUX_ONE: return 2'h0;
            sld_pkg::SLD_MUX_TWO: return 2'h1;
            sld_pkg::SLD_MUX_THREE: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction : last_phase

    // Control state
    sld_pkg::sld_ctrl_t ctrl_reg, ctrl_next;
    logic [NF-1:0] fpen_reg, fpen_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rd_ram_reg, rd_ram_next;
    logic [1:0] phase_reg, phase_next;
    logic frame_start_reg, frame_start_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        fpen_next = fpen_reg;
        rd_ram_next = reg_rd && is_ram(reg_addr);
        rdata_next = 8'h00;
        if (reg_wr) begin
            if (reg_addr == sld_pkg::OFF_CTRL0) begin
                ctrl_next.drive_enable = reg_wdata[sld_pkg::BIT_ENABLE];
                ctrl_next.bias_third = reg_wdata[sld_pkg::BIT_BIAS];
                ctrl_next.prescale = {reg_wdata[sld_pkg::BIT_PRESC_HI],
                                      reg_wdata[sld_pkg::BIT_PRESC_LO]};
                ctrl_next.mux = {reg_wdata[sld_pkg::BIT_MUX_HI], reg_wdata[sld_pkg::BIT_MUX_LO]};
            end
            for (int i = 0; i < 5; i++) begin
                if (reg_addr == sld_pkg::OFF_FPEN0 + 6'(i)) begin
                    fpen_next[i*8 +: 8] = reg_wdata;
                end
            end
        end
        if (reg_rd) begin
            if (reg_addr == sld_pkg::OFF_CTRL0) begin
                rdata_next[sld_pkg::BIT_ENABLE] = ctrl_reg.drive_enable;
                rdata_next[sld_pkg::BIT_BIAS] = ctrl_reg.bias_third;
                rdata_next[sld_pkg::BIT_PRESC_HI] = ctrl_reg.prescale[1];
                rdata_next[sld_pkg::BIT_PRESC_LO] = ctrl_reg.prescale[0];
                rdata_next[sld_pkg::BIT_MUX_HI] = ctrl_reg.mux[1];
                rdata_next[sld_pkg::BIT_MUX_LO] = ctrl_reg.mux[0];
            end
            for (int i = 0; i < 5; i++) begin
                if (reg_addr == sld_pkg::OFF_FPEN0 + 6'(i)) begin
                    rdata_next = fpen_reg[i*8 +: 8];
                end
            end
            if (reg_addr == sld_pkg::OFF_STATUS) begin
                rdata_next = {4'h0, frame_start_reg, ctrl_reg.drive_enable, phase_reg};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg.drive_enable <= 1'b0;
            ctrl_reg.bias_third <= sld_pkg::RST_BIAS;
            ctrl_reg.prescale <= sld_pkg::RST_PRESC;
            ctrl_reg.mux <= sld_pkg::RST_MUX;
            fpen_reg <= sld_pkg::RST_FPEN;
            rdata_reg <= 8'h00;
            rd_ram_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            fpen_reg <= fpen_next;
            rdata_reg <= rdata_next;
            rd_ram_reg <= rd_ram_next;
        end
    end

    // Segment memory: the bus port works whatever the drive enable says
    logic [7:0] ram_a_rdata, ram_b_rdata;
    logic [4:0] scan_reg, scan_next;
    sld_seg_ram u_ram (
        .ref_clk(ref_clk),
        .a_we(reg_wr && is_ram(reg_addr)),
        .a_addr(ram_index(reg_addr)),
        .a_wdata(reg_wdata),
        .a_rdata(ram_a_rdata),
        .b_addr(scan_reg),
        .b_rdata(ram_b_rdata)
    );
    // Control writes never reach the array
    always_comb begin
        reg_rdata = rd_ram_reg ? ram_a_rdata : rdata_reg;
    end

    // Slow source clock pin: two flops, then edge detect on the second
    logic src_s1_reg, src_s2_reg, src_s3_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            src_s1_reg <= 1'b0;
            src_s2_reg <= 1'b0;
            src_s3_reg <= 1'b0;
        end else begin
            src_s1_reg <= slow_source_clock;
            src_s2_reg <= src_s1_reg;
            src_s3_reg <= src_s2_reg;
        end
    end
    logic src_rise;
    assign src_rise = src_s2_reg && !src_s3_reg;

    // Prescaler and phase sequencer
    logic [9:0] div_reg, div_next, div_count;
    logic tick;
    always_comb begin
        case (ctrl_reg.prescale)
            2'b00: div_count = sld_pkg::DIV_64;
            2'b01: div_count = sld_pkg::DIV_128;
            2'b10: div_count = sld_pkg::DIV_256;
            default: div_count = sld_pkg::DIV_512;
        endcase
        div_next = div_reg;
        phase_next = phase_reg;
        tick = 1'b0;
        frame_start_next = 1'b0;
        if (!ctrl_reg.drive_enable) begin
            div_next = 10'h000;
            phase_next = 2'h0;
        end else if (ctrl_next.prescale != ctrl_reg.prescale) begin
            // Restart on a new prescale so a shorter count never meets a stale larger one
            div_next = 10'h000;
        end else if (src_rise) begin
            if (div_reg >= div_count - 10'h001) begin
                div_next = 10'h000;
                tick = 1'b1;
            end else begin
                div_next = div_reg + 10'h001;
            end
        end
        if (tick) begin
            if (phase_reg >= last_phase(ctrl_reg.mux)) begin
                phase_next = 2'h0;
                frame_start_next = 1'b1;
            end else begin
                phase_next = phase_reg + 2'h1;
            end
        end
    end

    // Engine scans the 20 bytes continuously so a whole copy is kept in flops
    logic [159:0] seg_reg, seg_next;
    logic [4:0] scan_d_reg;
    always_comb begin
        scan_next = (scan_reg == 5'(sld_pkg::SEG_BYTES - 1)) ? 5'h00 : scan_reg + 5'h01;
        seg_next = seg_reg;
        seg_next[scan_d_reg*8 +: 8] = ram_b_rdata;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div_reg <= 10'h000;
            phase_reg <= 2'h0;
            frame_start_reg <= 1'b0;
            scan_reg <= 5'h00;
            scan_d_reg <= 5'h00;
            seg_reg <= 160'h0;
        end else begin
            div_reg <= div_next;
            phase_reg <= phase_next;
            frame_start_reg <= frame_start_next;
            scan_reg <= scan_next;
            scan_d_reg <= scan_reg;
            seg_reg <= seg_next;
        end
    end

    // Level scheme: full bias uses levels 0/3, half 0/1(mid)/3, third all four.
    // Every other frame is inverted (alternating polarity), chosen by frame parity
    // to keep the panel DC free.
    logic pol_reg, pol_next;
    logic [1:0] nb_m1;
    logic half_b, full_b;
    always_comb begin
        nb_m1 = last_phase(ctrl_reg.mux);
        full_b = (ctrl_reg.mux == sld_pkg::SLD_MUX_ONE);
        half_b = (ctrl_reg.mux == sld_pkg::SLD_MUX_TWO) && !ctrl_reg.bias_third;
        pol_next = frame_start_next ? !pol_reg : pol_reg;
    end

    // Select: backplane active level is 3 (or 0 inverted); inactive 1 or 2 in third bias,
    // 1 (mid) in half bias. Frontplane ON is opposite extreme, OFF is the other mid level in third bias, 1 in half bias, the backplane level in full bias.
    function automatic logic [1:0] lv(input logic hi, input logic mid, input logic hb,
                                      input logic fb, input logic p);
        logic [1:0] r;
        r = 2'h0;
        if (!mid) begin
            r = (hi ^ p) ? 2'h3 : 2'h0;
        end else if (fb) begin
            // Full bias OFF follows the backplane so the cell sees no voltage
            r = p ? 2'h0 : 2'h3;
        end else if (hb) begin
            r = 2'h1;
        end else begin
            r = (hi ^ p) ? 2'h2 : 2'h1;
        end
        return r;
    endfunction : lv

    logic [1:0] bp_next [0:3];
    logic [3:0] bp_oe_next;
    logic [1:0] fp_next [0:39];
    logic [39:0] fp_oe_next;
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bp
            always_comb begin
                // Fixed per mode, independent of memory
                bp_next[g] = lv(1'b1, (2'(g) != phase_reg), half_b, 1'b0, pol_reg);
                bp_oe_next[g] = !(ctrl_reg.drive_enable && (2'(g) <= nb_m1));
            end
        end
        for (g = 0; g < NF; g++) begin : g_fp
            always_comb begin
                logic on;
                on = 1'b0;
                on = seg_reg[(g/2)*8 + (g%2)*4 + phase_reg];
                // ON drives the opposite extreme; OFF stays at a middle level, or follows the backplane in full bias
                fp_next[g] = lv(1'b0, !on, half_b, full_b && !on, pol_reg);
                fp_oe_next[g] = !(ctrl_reg.drive_enable && fpen_reg[g]);
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pol_reg <= 1'b0;
            backplane_oe_n <= 4'hf;
            frontplane_oe_n <= 40'hff_ffff_ffff;
            frame_start <= 1'b0;
            bias_half <= 1'b0;
            for (int i = 0; i < NB; i++) backplane_outputs[i] <= 2'h0;
            for (int i = 0; i < NF; i++) frontplane_outputs[i] <= 2'h0;
            for (int i = 0; i < NF; i++) fp_level[i] <= 8'h00;
        end else begin
            pol_reg <= pol_next;
            backplane_oe_n <= bp_oe_next;
            frontplane_oe_n <= fp_oe_next;
            frame_start <= frame_start_reg;
            bias_half <= half_b;
            for (int i = 0; i < NB; i++) backplane_outputs[i] <= bp_next[i];
            for (int i = 0; i < NF; i++) frontplane_outputs[i] <= fp_next[i];
            for (int i = 0; i < NF; i++) fp_level[i] <= 8'h00;
        end
    end

    property p_reset_float;
        @(posedge ref_clk) !rst_n |=> (backplane_oe_n == 4'hf) && (&frontplane_oe_n);
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pins not floated by reset");
    property p_reset_mode;
        @(posedge ref_clk) !rst_n |=> ctrl_reg.mux == 2'h0 && ctrl_reg.bias_third;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset mode wrong");
    property p_wrap;
        @(posedge ref_clk) disable iff (!rst_n) tick && phase_reg == nb_m1 |=> phase_reg == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("phase did not wrap");
    property p_frame;
        @(posedge ref_clk) disable iff (!rst_n) frame_start_reg |-> $past(tick);
    endproperty
    a_frame: assert property (p_frame) else $error("frame start without tick");
    property p_div;
        @(posedge ref_clk) disable iff (!rst_n) tick |-> div_reg == div_count - 10'h001;
    endproperty
    a_div: assert property (p_div) else $error("tick at wrong count");
    property p_unused_bp;
        @(posedge ref_clk) disable iff (!rst_n)
            ctrl_reg.mux == 2'b01 |=> backplane_oe_n[3:1] == 3'h7;
    endproperty
    a_unused_bp: assert property (p_unused_bp) else $error("unused backplane driven");
    property p_fp_gate;
        @(posedge ref_clk) disable iff (!rst_n)
            !ctrl_reg.drive_enable |=> &frontplane_oe_n;
    endproperty
    a_fp_gate: assert property (p_fp_gate) else $error("frontplane driven while off");
    property p_fp_start;
        @(posedge ref_clk) disable iff (!rst_n)
            ctrl_reg.drive_enable && fpen_reg[0] |=> !frontplane_oe_n[0];
    endproperty
    a_fp_start: assert property (p_fp_start) else $error("frontplane not started");
endmodule : sld_driver
`default_nettype wire

// ==== design/sld_pkg.sv ====
// Shared definitions for the segment display driver: register map, fields, resets, types.
// Assumes a byte-wide register port on a single 10 MHz clock.
package sld_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int NUM_FP = 40;
    localparam int NUM_BP = 4;
    localparam int SEG_BYTES = 20;
    localparam int RAM_AW = 5;
    // Register map (byte addresses)
    localparam logic [5:0] OFF_CTRL0 = 6'h00;
    localparam logic [5:0] OFF_FPEN0 = 6'h01;
    localparam logic [5:0] OFF_FPEN4 = 6'h05;
    localparam logic [5:0] OFF_STATUS = 6'h06;
    localparam logic [5:0] OFF_RAM0 = 6'h08;
    localparam logic [5:0] OFF_RAM_LAST = 6'h1b;
    // Control zero fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_BIAS = 4;
    localparam int BIT_PRESC_HI = 3;
    localparam int BIT_PRESC_LO = 2;
    localparam int BIT_MUX_HI = 1;
    localparam int BIT_MUX_LO = 0;
    // Reset values: four backplanes, third bias, drive off
    localparam logic [1:0] RST_MUX = 2'h0;
    localparam logic RST_BIAS = 1'b1;
    localparam logic [1:0] RST_PRESC = 2'h0;
    localparam logic [NUM_FP-1:0] RST_FPEN = 40'h00_0000_0000;
    // Prescale division counts
    localparam logic [9:0] DIV_64 = 10'h040;
    localparam logic [9:0] DIV_128 = 10'h080;
    localparam logic [9:0] DIV_256 = 10'h100;
    localparam logic [9:0] DIV_512 = 10'h200;
    // Drive levels on a pin, in quarters of the reference span (0..3 of V0..V3)
    typedef logic [1:0] sld_level_t;
    typedef enum logic [1:0] {
        SLD_MUX_FOUR = 2'b00,
        SLD_MUX_ONE = 2'b01,
        SLD_MUX_TWO = 2'b10,
        SLD_MUX_THREE = 2'b11
    } sld_mux_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sld_bus_req_t;
    typedef struct packed {
        logic drive_enable;
        logic bias_third;
        logic [1:0] prescale;
        logic [1:0] mux;
    } sld_ctrl_t;
endpackage : sld_pkg

// ==== design/sld_seg_ram.sv ====
// Dual-port segment memory, 20 bytes: port A is the register bus, port B the display engine.
// Assumes one clock; both read ports return data from a register one cycle later.
`timescale 1ns/100ps
`default_nettype none
module sld_seg_ram (
    input wire logic ref_clk, // Clock
    input wire logic a_we, // Bus write strobe
    input wire logic [4:0] a_addr, // Bus byte index
    input wire logic [7:0] a_wdata, // Bus write data
    output logic [7:0] a_rdata, // Bus read data, registered
    input wire logic [4:0] b_addr, // Engine byte index
    output logic [7:0] b_rdata // Engine read data, registered
);
    // No reset on the array: contents are undefined until software fills them
    logic [7:0] mem [0:19];
    always_ff @(posedge ref_clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule : sld_seg_ram
`default_nettype wire

// ==== verif/sld_panel.sv ====
// Passive segment glass model: records the widest level gap seen at each crossing.
// Assumes level codes 0..3 on every pin and low-active output enables.
`timescale 1ns/100ps
`default_nettype none
module sld_panel (
    input wire logic ref_clk, // Clock
    input wire logic clear, // Restarts the record
    input wire logic [1:0] backplane_outputs [0:3], // Backplane levels
    input wire logic [3:0] backplane_oe_n, // Backplane enables, low drives
    input wire logic [1:0] frontplane_outputs [0:39], // Frontplane levels
    input wire logic [39:0] frontplane_oe_n, // Frontplane enables, low drives
    output logic [1:0] max_diff [0:39][0:3] // Widest gap per crossing
);
    function automatic logic [1:0] gap(input logic [1:0] a, input logic [1:0] b);
        gap = (a > b) ? a - b : b - a;
    endfunction : gap
    // A floating pin puts no voltage on the cell, so only driven pairs count
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 40; i++) begin
            for (int j = 0; j < 4; j++) begin
                if (clear) begin
                    max_diff[i][j] <= 2'h0;
                end else if (!backplane_oe_n[j] && !frontplane_oe_n[i] &&
                             gap(backplane_outputs[j], frontplane_outputs[i]) >
                             max_diff[i][j]) begin
                    max_diff[i][j] <= gap(backplane_outputs[j], frontplane_outputs[i]);
                end
            end
        end
    end
endmodule : sld_panel
`default_nettype wire

// ==== verif/test_segment_lcd_driver.sv ====
// Self-checking bench for the segment display driver with a glass model.
// Assumes the slow source clock runs at a quarter of the 10 MHz ref_clk rate.
`timescale 1ns/100ps
`default_nettype none
module test_segment_lcd_driver;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic slow_source_clock = 1'b0;
    logic [1:0] src_cnt = 2'h0;
    logic [7:0] fp_level [0:39];
    logic [1:0] backplane_outputs [0:3];
    logic [3:0] backplane_oe_n;
    logic [1:0] frontplane_outputs [0:39];
    logic [39:0] frontplane_oe_n;
    logic frame_start;
    logic bias_half;
    logic clear = 1'b0;
    logic [1:0] max_diff [0:39][0:3];
    int bad_count = 0;
    int checks_done = 0;
    always #50 ref_clk = ~ref_clk;
    // Source edge every 4 ref cycles keeps tick spacing exact
    always @(posedge ref_clk) begin
        src_cnt <= src_cnt + 2'h1;
        if (src_cnt[0]) begin
            slow_source_clock <= ~slow_source_clock;
        end
    end
    sld_driver DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .slow_source_clock(slow_source_clock), .fp_level(fp_level),
        .backplane_outputs(backplane_outputs), .backplane_oe_n(backplane_oe_n),
        .frontplane_outputs(frontplane_outputs), .frontplane_oe_n(frontplane_oe_n),
        .frame_start(frame_start), .bias_half(bias_half));
    sld_panel glass (.ref_clk(ref_clk), .clear(clear), .backplane_outputs(backplane_outputs),
        .backplane_oe_n(backplane_oe_n), .frontplane_outputs(frontplane_outputs),
        .frontplane_oe_n(frontplane_oe_n), .max_diff(max_diff));
    task automatic tally_and_finish;
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_val(input string what, input logic [39:0] exp, input logic [39:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_cnt(input string what, input int exp, input int got);
        checks_done++;
        if (got != exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk_val("reg_rdata", {32'h0, exp}, {32'h0, d});
    endtask : rd_chk
    // Cycles from one frame pulse to the next; a lost pulse ends the run
    task automatic frame_gap(output int n);
        n = 0;
        for (int k = 0; k < 20000 && frame_start !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (frame_start !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : frame_gap
    task automatic do_reset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task automatic check_reset;
        chk_val("frontplane_oe_n", 40'hff_ffff_ffff, frontplane_oe_n);
        chk_val("backplane_oe_n", 40'hf, {36'h0, backplane_oe_n});
        chk_val("fp_level", 40'h0, {32'h0, fp_level[39]});
        rd_chk(sld_pkg::OFF_CTRL0, 8'h10);
        rd_chk(sld_pkg::OFF_STATUS, 8'h00);
        for (int k = 0; k < 5; k++) begin
            rd_chk(sld_pkg::OFF_FPEN0 + 6'(k), 8'h00);
        end
    endtask : check_reset
    task automatic t_ram;
        for (int k = 0; k < 20; k++) begin
            wr(sld_pkg::OFF_RAM0 + 6'(k), 8'(k * 37 + 3));
        end
        wr(6'h07, 8'hff);
        wr(6'h1c, 8'hff);
        rd_chk(6'h07, 8'h00);
        rd_chk(6'h1c, 8'h00);
        wr(sld_pkg::OFF_CTRL0, 8'h91);
        rd_chk(sld_pkg::OFF_CTRL0, 8'h91);
        wr(sld_pkg::OFF_CTRL0, 8'h10);
        for (int k = 0; k < 20; k++) begin
            rd_chk(sld_pkg::OFF_RAM0 + 6'(k), 8'(k * 37 + 3));
        end
    endtask : t_ram
    task automatic t_timing;
        int n;
        int nbp [4] = '{4, 1, 2, 3};
        logic [3:0] oe [4] = '{4'h0, 4'he, 4'hc, 4'h8};
        for (int p = 0; p < 4; p++) begin
            wr(sld_pkg::OFF_CTRL0, 8'h81 | 8'(p << 2));
            frame_gap(n);
            frame_gap(n);
            chk_cnt("frame cycles", 256 << p, n);
        end
        for (int m = 0; m < 4; m++) begin
            wr(sld_pkg::OFF_CTRL0, 8'h80 | 8'(m));
            frame_gap(n);
            frame_gap(n);
            chk_cnt("frame cycles", 256 * nbp[m], n);
            chk_val("backplane_oe_n", {36'h0, oe[m]}, {36'h0, backplane_oe_n});
            chk_val("bias_half", {39'h0, m == 2}, {39'h0, bias_half});
        end
        wr(sld_pkg::OFF_CTRL0, 8'h92);
        repeat (3) @(posedge ref_clk);
        chk_val("bias_half", 40'h0, {39'h0, bias_half});
    endtask : t_timing
    task automatic t_enable;
        wr(sld_pkg::OFF_CTRL0, 8'h10);
        wr(sld_pkg::OFF_FPEN0, 8'h03);
        repeat (3) @(posedge ref_clk);
        chk_val("frontplane_oe_n", 40'hff_ffff_ffff, frontplane_oe_n);
        wr(sld_pkg::OFF_CTRL0, 8'h90);
        repeat (3) @(posedge ref_clk);
        chk_val("frontplane_oe_n", 40'hff_ffff_fffc, frontplane_oe_n);
        wr(sld_pkg::OFF_FPEN4, 8'h80);
        repeat (3) @(posedge ref_clk);
        chk_val("frontplane_oe_n", 40'h7f_ffff_fffc, frontplane_oe_n);
    endtask : t_enable
    task automatic t_segments;
        int n;
        logic lit;
        for (int k = 0; k < 20; k++) begin
            wr(sld_pkg::OFF_RAM0 + 6'(k), 8'h00);
        end
        wr(sld_pkg::OFF_RAM0, 8'h21);
        wr(sld_pkg::OFF_RAM_LAST, 8'h80);
        frame_gap(n);
        @(posedge ref_clk);
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        frame_gap(n);
        frame_gap(n);
        for (int j = 0; j < 4; j++) begin
            lit = (j == 0);
            chk_val("fp0 on", {39'h0, lit}, {39'h0, max_diff[0][j] == 2'h3});
            lit = (j == 1);
            chk_val("fp1 on", {39'h0, lit}, {39'h0, max_diff[1][j] == 2'h3});
            lit = (j == 3);
            chk_val("fp39 on", {39'h0, lit}, {39'h0, max_diff[39][j] == 2'h3});
        end
        // One backplane, full bias: OFF must leave the cell at zero
        wr(sld_pkg::OFF_CTRL0, 8'h81);
        frame_gap(n);
        @(posedge ref_clk);
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        frame_gap(n);
        chk_val("fp0 on one bp", 40'h1, {39'h0, max_diff[0][0] == 2'h3});
        chk_val("fp1 off one bp", 40'h0, {38'h0, max_diff[1][0]});
    endtask : t_segments
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check_reset();
        t_ram();
        t_timing();
        t_enable();
        t_segments();
        do_reset();
        #1;
        check_reset();
        tally_and_finish();
    end
endmodule : test_segment_lcd_driver
`default_nettype wire
